// ==== hdl/aidc_pkg.sv ====
/*
  Constants, field layouts and types for the accessory impedance detect
  control block. Assumes a 100 MHz core clock and an AXI4-Lite master with
  32-bit data. Registers are addressed by index, byte address = 4 * index.
*/
// How it works
// [R1] classify impedance into eight levels, incl. none
// [R2] function selector: 00/11 mic, 01 left, 10 right
// [R3] bit 13 picks pin A or B; feedback opposite
// [R4] bits 5:4 pick supply rail or bias 1-3
// [R5] detect only in mic mode with enable set
// [R6] cyclic measurements with coded interval gap
// [R7] warm-up delay when bias not already on
// [R8] bias reference requested automatically per measurement
// [R9] accept after 2 or 4 matching measurements
// [R10] settled result sets valid, publishes level, presence
// [R11] valid stays while enabled; only fields update
// [R12] nine-bit one-hot level at bits 10:2
// [R13] presence bit set below 30k ohm
// [R14] eight-bit mask enables each level separately, except the lowest and none
// [R15] software writes zero to mask bits 6, 5
// [R16] event on insertion, removal or level change
// [R17] gpio pulse per event when routed
// [R18] software runs one detection at a time
// [R19] disabled level reports next lower enabled level
// [R20] clearing enable stops cycle, clears valid
package aidc_pkg;

  // register indices; byte address is four times these
  localparam logic [9:0] IDX_MODE   = 10'h293;  // accessory_sense_mode
  localparam logic [9:0] IDX_CTRL   = 10'h2a3;  // mic_sense_control
  localparam logic [9:0] IDX_MASK   = 10'h2a4;  // mic_sense_level_mask
  localparam logic [9:0] IDX_RESULT = 10'h2a5;  // mic_sense_result
  localparam logic [9:0] IDX_EVCTL  = 10'h2a6;  // event_control

  // field positions
  localparam int MODE_PIN_BIT  = 13;  // sense_pin_select
  localparam int EVCTL_GPIO_BIT = 0;  // gpio routing enable

  // reset values
  localparam logic [15:0] MODE_RST  = 16'h0000;
  localparam logic [15:0] CTRL_RST  = 16'h1102;
  localparam logic [15:0] MASK_RST  = 16'h009f;
  localparam logic        EVCTL_RST = 1'h0;

  // timing: one delay unit is 0.25 ms
  localparam int unsigned CLK_MHZ     = 100;
  localparam int unsigned UNIT_US     = 250;
  localparam int unsigned UNIT_CYCLES = UNIT_US * CLK_MHZ;
  localparam logic [11:0] DELAY_MAX_UNITS = 12'h800;  // 512 ms
  localparam logic [3:0]  DELAY_CAP_CODE  = 4'hc;

  // debounce lengths and raw level codes
  localparam logic [2:0] SETTLE_SHORT = 3'h2;
  localparam logic [2:0] SETTLE_LONG  = 3'h4;
  localparam logic [2:0] RAW_HIGH     = 3'h6;  // above 475 ohm
  localparam logic [2:0] RAW_NONE     = 3'h7;  // nothing connected

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // mic_sense_control layout
  typedef struct packed {
    logic [3:0] warmup;       // bias_warmup_delay code
    logic [3:0] interval;     // gap between measurements
    logic [1:0] rsvd_7_6;
    logic [1:0] ref_sel;      // reference_select
    logic [1:0] rsvd_3_2;
    logic       settle_long;  // settle_count_select
    logic       enable;       // mic_sense_enable
  } aidc_ctrl_t;

  // mic_sense_result layout
  typedef struct packed {
    logic [4:0] rsvd;
    logic [8:0] level;        // impedance_level one-hot
    logic       valid;
    logic       present;      // accessory_present
  } aidc_result_t;

  typedef enum logic [2:0] {ST_IDLE, ST_WARM, ST_MEAS, ST_RELEASE, ST_WAIT} aidc_state_t;

endpackage : aidc_pkg

// ==== hdl/aidc_top.sv ====
/*
  Accessory impedance detect control: AXI4-Lite register file, measurement
  scheduler, debounce and result publishing. Assumes an analogue measurement
  front end that answers meas_req_r with meas_ack high and a stable raw level
  code while ack is high; ack and raw arrive asynchronously.
*/
// Register access over AXI4-Lite was chosen for this implementation.
module aidc_top #(
  parameter int unsigned UNIT_CYCLES = aidc_pkg::UNIT_CYCLES  // cycles per 0.25 ms
) (
  input  logic        core_clk,
  input  logic        rst,
  // AXI4-Lite slave
  input  logic [11:0] s_axi_awaddr,
  input  logic        s_axi_awvalid,
  output logic        s_axi_awready,
  input  logic [31:0] s_axi_wdata,
  input  logic [3:0]  s_axi_wstrb,
  input  logic        s_axi_wvalid,
  output logic        s_axi_wready,
  output logic [1:0]  s_axi_bresp,
  output logic        s_axi_bvalid,
  input  logic        s_axi_bready,
  input  logic [11:0] s_axi_araddr,
  input  logic        s_axi_arvalid,
  output logic        s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0]  s_axi_rresp,
  output logic        s_axi_rvalid,
  input  logic        s_axi_rready,
  // analogue front end
  input  logic        meas_ack,
  input  logic [2:0]  meas_raw,
  input  logic [2:0]  bias_sw_on,
  output logic        meas_req_r,
  output logic [2:0]  bias_req_r,
  output logic [1:0]  ref_select_r,
  output logic        route_pin_b_r,
  output logic        hp_left_sense_r,
  output logic        hp_right_sense_r,
  // events
  output logic        irq_event_r,
  output logic        gpio_pulse_r
);

  // delay code to 0.25 ms units, shared by warm-up and interval
  function automatic logic [11:0] delay_units(input logic [3:0] code);
    logic [11:0] u;
    u = 12'h000;
    if (code >= aidc_pkg::DELAY_CAP_CODE) begin
      u = aidc_pkg::DELAY_MAX_UNITS;
    end else if (code != 4'h0) begin
      u = 12'h001 << (code - 4'h1);
    end
    return u;
  endfunction : delay_units

  // apply byte strobes to a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [15:0] m;
    m = old;
    if (s[0]) begin
      m[7:0] = d[7:0];
    end
    if (s[1]) begin
      m[15:8] = d[15:8];
    end
    return m;
  endfunction : merge16

  // raw code to one-hot level, folding disabled levels downward
  function automatic logic [8:0] level_fold(input logic [2:0] raw, input logic [7:0] mask);
    logic [2:0] cur;
    logic [6:0] en;
    logic [8:0] oh;
    en  = {mask[7], mask[4:0], 1'b1};  // [R14] lowest level always on
    cur = raw;
    oh  = 9'h000;
    if (raw != aidc_pkg::RAW_NONE) begin
      for (int i = 6; i > 0; i--) begin
        if (cur == 3'(i) && !en[i]) begin
          cur = 3'(i - 1);  // [R19]
        end
      end
      if (cur == aidc_pkg::RAW_HIGH) begin
        oh[8] = 1'b1;  // [R12]
      end else begin
        oh[cur] = 1'b1;  // [R12]
      end
    end
    return oh;
  endfunction : level_fold

  // register file state
  logic [15:0]         mode_r,  mode_nxt;    // accessory_sense_mode
  aidc_pkg::aidc_ctrl_t ctrl_r, ctrl_nxt;    // mic_sense_control
  logic [7:0]          mask_r,  mask_nxt;    // mic_sense_level_mask
  logic                evctl_r, evctl_nxt;   // gpio routing enable

  // bus state
  logic        aw_have_r, aw_have_nxt;
  logic [9:0]  aw_idx_r,  aw_idx_nxt;
  logic        w_have_r,  w_have_nxt;
  logic [31:0] w_data_r,  w_data_nxt;
  logic [3:0]  w_strb_r,  w_strb_nxt;
  logic        awready_r, awready_nxt;
  logic        wready_r,  wready_nxt;
  logic        bvalid_r,  bvalid_nxt;
  logic [1:0]  bresp_r,   bresp_nxt;
  logic        arready_r, arready_nxt;
  logic        rvalid_r,  rvalid_nxt;
  logic [1:0]  rresp_r,   rresp_nxt;
  logic [31:0] rdata_r,   rdata_nxt;

  // detection state
  aidc_pkg::aidc_state_t state_r, state_nxt;
  logic [31:0] tick_r,     tick_nxt;       // prescaler within a unit
  logic [11:0] units_r,    units_nxt;      // remaining delay units
  logic [2:0]  last_raw_r, last_raw_nxt;   // previous measurement
  logic [2:0]  match_r,    match_nxt;      // agreeing measurements
  logic [8:0]  level_r,    level_nxt;
  logic        present_r,  present_nxt;
  logic        valid_r,    valid_nxt;
  logic        req_nxt;
  logic [2:0]  bias_nxt;
  logic        irq_nxt,    gpio_nxt;

  // synchronisers for the asynchronous front end
  logic       ack_m_r, ack_s_r;
  logic [2:0] raw_m_r, raw_s_r;

  aidc_pkg::aidc_result_t result;
  logic       det_en;
  logic       needs_bias;
  logic       needs_warm;
  logic [2:0] bias_sel;
  logic       unit_done;

  // result register view
  always_comb begin
    result         = '0;
    result.level   = level_r;
    result.valid   = valid_r;
    result.present = present_r;
  end

  // enable decode and bias needs
  always_comb begin
    det_en     = ctrl_r.enable && (mode_r[1] == mode_r[0]);  // [R2] [R5]
    needs_bias = (ctrl_r.ref_sel != 2'h0);                    // [R4]
    bias_sel   = 3'h0;
    if (needs_bias) begin
      bias_sel = 3'h1 << (ctrl_r.ref_sel - 2'h1);
    end
    needs_warm = needs_bias && ((bias_sw_on & bias_sel) == 3'h0);  // [R7]
    unit_done  = (tick_r == UNIT_CYCLES - 1);
  end

  // bus next state: write and read channels
  always_comb begin
    aw_have_nxt = aw_have_r;
    aw_idx_nxt  = aw_idx_r;
    w_have_nxt  = w_have_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    mode_nxt    = mode_r;
    ctrl_nxt    = ctrl_r;
    mask_nxt    = mask_r;
    evctl_nxt   = evctl_r;
    // response taken
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    // address and data may arrive in either order
    if (s_axi_awvalid && awready_r) begin
      aw_have_nxt = 1'b1;
      aw_idx_nxt  = s_axi_awaddr[11:2];
    end
    if (s_axi_wvalid && wready_r) begin
      w_have_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    // commit once both halves are held and the response slot is free
    if (aw_have_nxt && w_have_nxt && !bvalid_nxt) begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = aidc_pkg::RESP_OKAY;
      unique case (aw_idx_nxt)
        aidc_pkg::IDX_MODE: begin
          mode_nxt = merge16(mode_r, w_data_nxt, w_strb_nxt);
        end
        aidc_pkg::IDX_CTRL: begin
          ctrl_nxt = merge16(ctrl_r, w_data_nxt, w_strb_nxt);
        end
        aidc_pkg::IDX_MASK: begin
          if (w_strb_nxt[0]) begin
            mask_nxt = w_data_nxt[7:0];  // [R15] bits 6:5 kept, never read by logic
          end
        end
        aidc_pkg::IDX_EVCTL: begin
          if (w_strb_nxt[0]) begin
            evctl_nxt = w_data_nxt[aidc_pkg::EVCTL_GPIO_BIT];
          end
        end
        aidc_pkg::IDX_RESULT: begin
          bresp_nxt = aidc_pkg::RESP_OKAY;  // read-only, write ignored
        end
        default: begin
          bresp_nxt = aidc_pkg::RESP_SLVERR;  // unmapped
        end
      endcase
    end
    // read: one outstanding at a time
    if (s_axi_arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = aidc_pkg::RESP_OKAY;
      rdata_nxt  = 32'h0000_0000;
      unique case (s_axi_araddr[11:2])
        aidc_pkg::IDX_MODE:   rdata_nxt[15:0] = mode_r;
        aidc_pkg::IDX_CTRL:   rdata_nxt[15:0] = ctrl_r;
        aidc_pkg::IDX_MASK:   rdata_nxt[7:0]  = mask_r;
        aidc_pkg::IDX_RESULT: rdata_nxt[15:0] = result;  // [R10]
        aidc_pkg::IDX_EVCTL:  rdata_nxt[aidc_pkg::EVCTL_GPIO_BIT] = evctl_r;
        default: begin
          rresp_nxt = aidc_pkg::RESP_SLVERR;  // unmapped reads zero
        end
      endcase
    end
    awready_nxt = !aw_have_nxt && !bvalid_nxt;
    wready_nxt  = !w_have_nxt && !bvalid_nxt;
    arready_nxt = !rvalid_nxt;
  end

  // bus and register file flops
  always_ff @(posedge core_clk) begin
    if (rst) begin
      aw_have_r <= 1'b0;
      aw_idx_r  <= 10'h000;
      w_have_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= aidc_pkg::RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rresp_r   <= aidc_pkg::RESP_OKAY;
      rdata_r   <= 32'h0000_0000;
      mode_r    <= aidc_pkg::MODE_RST;
      ctrl_r    <= aidc_pkg::CTRL_RST;
      mask_r    <= aidc_pkg::MASK_RST[7:0];
      evctl_r   <= aidc_pkg::EVCTL_RST;
    end else begin
      aw_have_r <= aw_have_nxt;
      aw_idx_r  <= aw_idx_nxt;
      w_have_r  <= w_have_nxt;
      w_data_r  <= w_data_nxt;
      w_strb_r  <= w_strb_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
      mode_r    <= mode_nxt;
      ctrl_r    <= ctrl_nxt;
      mask_r    <= mask_nxt;
      evctl_r   <= evctl_nxt;
    end
  end

  // two-flop synchronisers; raw is only sampled after ack settles
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_m_r <= 1'b0;
      ack_s_r <= 1'b0;
      raw_m_r <= aidc_pkg::RAW_NONE;
      raw_s_r <= aidc_pkg::RAW_NONE;
    end else begin
      ack_m_r <= meas_ack;
      ack_s_r <= ack_m_r;
      raw_m_r <= meas_raw;
      raw_s_r <= raw_m_r;
    end
  end

  // scheduler, debounce and publishing
  always_comb begin
    state_nxt    = state_r;
    tick_nxt     = 32'h0000_0000;
    units_nxt    = units_r;
    last_raw_nxt = last_raw_r;
    match_nxt    = match_r;
    level_nxt    = level_r;
    present_nxt  = present_r;
    valid_nxt    = valid_r;
    req_nxt      = 1'b0;
    irq_nxt      = 1'b0;
    gpio_nxt     = 1'b0;
    // prescaler runs only while a delay is counting
    if ((state_r == aidc_pkg::ST_WARM || state_r == aidc_pkg::ST_WAIT) && units_r != 12'h000) begin
      tick_nxt = unit_done ? 32'h0000_0000 : tick_r + 32'h0000_0001;
      if (unit_done) begin
        units_nxt = units_r - 12'h001;
      end
    end
    if (!det_en) begin
      state_nxt = aidc_pkg::ST_IDLE;  // [R20]
      valid_nxt = 1'b0;               // [R20]
      match_nxt = 3'h0;
    end else begin
      unique case (state_r)
        aidc_pkg::ST_IDLE: begin
          // a stale ack from an aborted run must clear first
          if (!ack_s_r) begin
            state_nxt = aidc_pkg::ST_WARM;
            units_nxt = needs_warm ? delay_units(ctrl_r.warmup) : 12'h000;  // [R7]
          end
        end
        aidc_pkg::ST_WARM: begin
          if (units_r == 12'h000) begin
            state_nxt = aidc_pkg::ST_MEAS;
          end
        end
        aidc_pkg::ST_MEAS: begin
          req_nxt = 1'b1;
          if (ack_s_r) begin
            req_nxt      = 1'b0;
            state_nxt    = aidc_pkg::ST_RELEASE;
            last_raw_nxt = raw_s_r;  // [R1]
            if (raw_s_r == last_raw_r) begin
              if (match_r != aidc_pkg::SETTLE_LONG) begin
                match_nxt = match_r + 3'h1;  // [R9]
              end
            end else begin
              match_nxt = 3'h1;  // [R9] disagreement restarts the count
            end
            if (match_nxt >= (ctrl_r.settle_long ? aidc_pkg::SETTLE_LONG : aidc_pkg::SETTLE_SHORT)) begin
              level_nxt   = level_fold(raw_s_r, mask_r);        // [R12] [R19]
              present_nxt = (raw_s_r != aidc_pkg::RAW_NONE);    // [R13]
              valid_nxt   = 1'b1;                               // [R10] [R11]
              if (!valid_r || level_nxt != level_r || present_nxt != present_r) begin
                irq_nxt  = 1'b1;     // [R16]
                gpio_nxt = evctl_r;  // [R17]
              end
            end
          end
        end
        aidc_pkg::ST_RELEASE: begin
          if (!ack_s_r) begin
            state_nxt = aidc_pkg::ST_WAIT;
            units_nxt = delay_units(ctrl_r.interval);  // [R6]
          end
        end
        aidc_pkg::ST_WAIT: begin
          if (units_r == 12'h000) begin
            state_nxt = aidc_pkg::ST_WARM;  // [R6]
            units_nxt = needs_warm ? delay_units(ctrl_r.warmup) : 12'h000;  // [R7]
          end
        end
        default: begin
          state_nxt = aidc_pkg::ST_IDLE;
        end
      endcase
    end
    // bias held only around the measurement, so standby draws little
    bias_nxt = 3'h0;
    if (state_nxt == aidc_pkg::ST_WARM || state_nxt == aidc_pkg::ST_MEAS || state_nxt == aidc_pkg::ST_RELEASE) begin
      bias_nxt = bias_sel;  // [R8]
    end
  end

  // detection flops and registered pin outputs
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r          <= aidc_pkg::ST_IDLE;
      tick_r           <= 32'h0000_0000;
      units_r          <= 12'h000;
      last_raw_r       <= aidc_pkg::RAW_NONE;
      match_r          <= 3'h0;
      level_r          <= 9'h000;
      present_r        <= 1'b0;
      valid_r          <= 1'b0;
      meas_req_r       <= 1'b0;
      bias_req_r       <= 3'h0;
      irq_event_r      <= 1'b0;
      gpio_pulse_r     <= 1'b0;
      ref_select_r     <= 2'h0;
      route_pin_b_r    <= 1'b0;
      hp_left_sense_r  <= 1'b0;
      hp_right_sense_r <= 1'b0;
    end else begin
      state_r          <= state_nxt;
      tick_r           <= tick_nxt;
      units_r          <= units_nxt;
      last_raw_r       <= last_raw_nxt;
      match_r          <= match_nxt;
      level_r          <= level_nxt;
      present_r        <= present_nxt;
      valid_r          <= valid_nxt;
      meas_req_r       <= req_nxt;
      bias_req_r       <= bias_nxt;
      irq_event_r      <= irq_nxt;
      gpio_pulse_r     <= gpio_nxt;
      ref_select_r     <= ctrl_r.ref_sel;                 // [R4]
      route_pin_b_r    <= mode_r[aidc_pkg::MODE_PIN_BIT];  // [R3]
      hp_left_sense_r  <= (mode_r[1:0] == 2'h1);           // [R2]
      hp_right_sense_r <= (mode_r[1:0] == 2'h2);           // [R2]
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;

endmodule : aidc_top

// ==== tb/aidc_monitor.sv ====
/*
  Checker for the accessory detect block, bound to its top module.
  Assumes one core_clk domain with synchronous active-high rst.
*/
module aidc_monitor (
  input logic       core_clk,
  input logic       rst,
  input logic       meas_ack,
  input logic       meas_req_r,
  input logic [2:0] bias_req_r,
  input logic [1:0] ref_select_r,
  input logic       hp_left_sense_r,
  input logic       hp_right_sense_r,
  input logic       irq_event_r,
  input logic       gpio_pulse_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // request must end shortly after the front end answers
  sequence req_drop_s;
    ##[1:4] !meas_req_r;
  endsequence
  // quiet gap after a request, ack sync alone takes that long
  sequence req_gap_s;
    !meas_req_r [*3];
  endsequence

  chk_req_hold: assert property (meas_req_r && !meas_ack |=> meas_req_r)
    else $error("request dropped before answer");
  chk_req_drop: assert property (meas_req_r && meas_ack |-> req_drop_s)
    else $error("request not released after answer");
  chk_req_gap: assert property ($fell(meas_req_r) |-> req_gap_s)
    else $error("request restarted too soon");
  chk_irq_single: assert property (irq_event_r |=> !irq_event_r)
    else $error("event longer than one cycle");
  chk_irq_cause: assert property (irq_event_r |-> $fell(meas_req_r))
    else $error("event without finished measurement");
  chk_gpio_gate: assert property (gpio_pulse_r |-> irq_event_r)
    else $error("gpio pulse without event");
  chk_bias_match: assert property ($stable(ref_select_r) && bias_req_r != 3'h0 |->
    ref_select_r != 2'h0 && bias_req_r == 3'h1 << (ref_select_r - 2'h1))
    else $error("bias request does not match reference");
  chk_hp_mutex: assert property (!(hp_left_sense_r && hp_right_sense_r))
    else $error("both headphone senses selected");
  chk_hp_idle: assert property (hp_left_sense_r || hp_right_sense_r |-> !$rose(meas_req_r))
    else $error("measurement started in headphone mode");
endmodule : aidc_monitor

bind aidc_top aidc_monitor i_aidc_monitor (
  .core_clk        (core_clk),
  .rst             (rst),
  .meas_ack        (meas_ack),
  .meas_req_r      (meas_req_r),
  .bias_req_r      (bias_req_r),
  .ref_select_r    (ref_select_r),
  .hp_left_sense_r (hp_left_sense_r),
  .hp_right_sense_r(hp_right_sense_r),
  .irq_event_r     (irq_event_r),
  .gpio_pulse_r    (gpio_pulse_r)
);

// ==== tb/aidc_front_model.sv ====
/*
  Behavioural front end and accessory load: answers each request still held when its conversion ends.
  Assumes meas_req_r from the block and a level code from the bench.
*/
module aidc_front_model (
  input  logic       core_clk,
  input  logic       meas_req_r,
  input  logic [2:0] raw_code,
  input  logic       slow,
  output logic       meas_ack,
  output logic [2:0] meas_raw
);
  timeunit 1ns;
  timeprecision 1ps;
  // one conversion per request, short or long
  initial begin
    meas_ack = 1'b0;
    meas_raw = 3'h0;
    forever begin
      @(posedge core_clk);
      if (meas_req_r === 1'b1) begin
        repeat (slow ? 12 : 1) @(posedge core_clk);
        meas_raw <= raw_code;  // code settles before ack
        @(posedge core_clk);
        if (meas_req_r === 1'b1) begin  // no answer to a withdrawn request
          meas_ack <= 1'b1;
          while (meas_req_r !== 1'b0) @(posedge core_clk);
          meas_ack <= 1'b0;
        end
        @(posedge core_clk);
        meas_raw <= ~raw_code;  // released code is garbage
      end
    end
  end
endmodule : aidc_front_model

// ==== tb/test_accessory_impedance_detect_control.sv ====
/*
  Self-checking bench: AXI4-Lite register tasks and detection scenarios.
  Assumes aidc_pkg, aidc_top and the front-end model; UNIT_CYCLES cut to 4.
*/
module test_accessory_impedance_detect_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] rsp_ok  = aidc_pkg::RESP_OKAY;
  localparam logic [1:0] rsp_err = aidc_pkg::RESP_SLVERR;
  logic        core_clk, rst;  // clock, reset
  logic [11:0] awaddr, araddr;  // byte addresses
  logic [31:0] wdata, rdata;  // bus data
  logic [3:0]  wstrb;  // all lanes on
  logic [1:0]  bresp, rresp;  // responses
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        meas_ack, meas_req_r, slow;  // front end
  logic [2:0]  meas_raw, raw_code, bias_sw_on, bias_req_r;
  logic [1:0]  ref_select_r;
  logic        route_pin_b_r, hp_left_sense_r, hp_right_sense_r, irq_event_r, gpio_pulse_r;
  int          err_total, samples_checked;  // verdict counters

  aidc_top #(.UNIT_CYCLES(4)) i_aidc_top (
    .core_clk(core_clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .meas_ack(meas_ack), .meas_raw(meas_raw), .bias_sw_on(bias_sw_on),
    .meas_req_r(meas_req_r), .bias_req_r(bias_req_r), .ref_select_r(ref_select_r),
    .route_pin_b_r(route_pin_b_r), .hp_left_sense_r(hp_left_sense_r),
    .hp_right_sense_r(hp_right_sense_r), .irq_event_r(irq_event_r), .gpio_pulse_r(gpio_pulse_r));

  aidc_front_model i_aidc_front_model (
    .core_clk(core_clk), .meas_req_r(meas_req_r), .raw_code(raw_code),
    .slow(slow), .meas_ack(meas_ack), .meas_raw(meas_raw));

  // free-running 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic summarize;
    $display("errors %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  // one clock with a bound on any wait
  task automatic tick(inout int n);
    @(posedge core_clk);
    n++;
    if (n > 3000) begin
      err_total++;
      $display("mismatch wait expected done seen timeout");
      summarize();
    end
  endtask : tick

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // write: address and data offered together, each released when taken
  task automatic wr_chk(input string what, input logic [9:0] idx, input logic [15:0] d, input logic [1:0] er);
    int n = 0;
    awaddr  <= {idx, 2'h0};
    wdata   <= {16'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      tick(n);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    check({what, " bresp"}, {30'h0, er}, {30'h0, bresp});
  endtask : wr_chk

  task automatic rd_chk(input string what, input logic [9:0] idx, input logic [31:0] exp, input logic [1:0] er);
    int n = 0;
    araddr  <= {idx, 2'h0};
    arvalid <= 1'b1;
    do begin
      tick(n);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    check(what, exp, rdata);
    check({what, " rresp"}, {30'h0, er}, {30'h0, rresp});
  endtask : rd_chk

  // one-hot level after folding disabled levels downward
  function automatic logic [31:0] res(input logic [2:0] raw, input logic [7:0] m, input logic v);
    int k;
    k = (raw == 3'h7) ? -1 : (raw == 3'h6) ? 8 : int'(raw);
    if (k == 8 && !m[7]) k = 5;
    while (k > 0 && k <= 5 && !m[k-1]) k--;
    res = {21'h0, (k < 0) ? 9'h0 : 9'h1 << k, v, raw != 3'h7};
  endfunction : res

  task automatic t_defaults;
    rd_chk("mode", aidc_pkg::IDX_MODE, 32'h0, rsp_ok);
    rd_chk("control", aidc_pkg::IDX_CTRL, 32'h1102, rsp_ok);
    rd_chk("mask", aidc_pkg::IDX_MASK, 32'h9f, rsp_ok);
    wr_chk("result write", aidc_pkg::IDX_RESULT, 16'hffff, rsp_ok);
    rd_chk("result", aidc_pkg::IDX_RESULT, 32'h0, rsp_ok);
    wr_chk("unmapped write", 10'h001, 16'h1234, rsp_err);
    rd_chk("unmapped", 10'h001, 32'h0, rsp_err);
  endtask : t_defaults

  // every function code, pin select alternating; ends in mic mode 11
  task automatic t_routing;
    for (int m = 0; m < 4; m++) begin
      wr_chk("mode", aidc_pkg::IDX_MODE, {2'h0, m[0], 11'h0, m[1:0]}, rsp_ok);
      wr_chk("hp enable", aidc_pkg::IDX_CTRL, {15'h0, m == 1}, rsp_ok);
      repeat (4) @(posedge core_clk);
      check("pin b", m[0], route_pin_b_r);
      check("left", m == 1, hp_left_sense_r);
      check("right", m == 2, hp_right_sense_r);
      check("hp idle", 1'b0, meas_req_r);
    end
  endtask : t_routing

  // fresh enable, count measurements to first publish, then a change
  task automatic t_detect(input logic [2:0] raw, input logic [7:0] mask, input logic [1:0] rf,
                          input logic lng, input logic gp, input logic [2:0] nxt);
    int n, cnt;
    logic pr, gs;
    n = 0;
    cnt = 0;
    pr = 1'b0;
    raw_code <= raw;
    slow <= lng;
    wr_chk("mask", aidc_pkg::IDX_MASK, {8'h0, mask}, rsp_ok);
    wr_chk("gpio route", aidc_pkg::IDX_EVCTL, {15'h0, gp}, rsp_ok);
    wr_chk("enable", aidc_pkg::IDX_CTRL, {8'h13, 2'h0, rf, 2'h0, lng, 1'b1}, rsp_ok);
    do begin
      tick(n);
      if (meas_req_r && bias_sw_on == 3'h0)
        check("bias", rf == 2'h0 ? 3'h0 : 3'h1 << (rf - 2'h1), bias_req_r);
      if (pr && !meas_req_r) cnt++;
      pr = meas_req_r;
      gs = gpio_pulse_r;
    end while (!irq_event_r);
    check("settle count", lng ? 4 : 2, cnt);
    check("ref", rf, ref_select_r);
    check("gpio", gp, gs);
    rd_chk("result", aidc_pkg::IDX_RESULT, res(raw, mask, 1'b1), rsp_ok);
    raw_code <= nxt;
    n = 0;
    do tick(n); while (!irq_event_r);
    rd_chk("changed", aidc_pkg::IDX_RESULT, res(nxt, mask, 1'b1), rsp_ok);
    wr_chk("disable", aidc_pkg::IDX_CTRL, {8'h13, 2'h0, rf, 2'h0, lng, 1'b0}, rsp_ok);
    repeat (30) @(posedge core_clk);
    check("idle", 1'b0, meas_req_r);
    rd_chk("cleared", aidc_pkg::IDX_RESULT, res(nxt, mask, 1'b0), rsp_ok);
  endtask : t_detect

  // main sequence
  initial begin
    err_total = 0;
    samples_checked = 0;
    rst = 1'b1;
    {awaddr, araddr, wdata, awvalid, wvalid, arvalid} = '0;
    wstrb = 4'hf;
    bready = 1'b1;
    rready = 1'b1;
    bias_sw_on = 3'h0;
    raw_code = 3'h7;
    slow = 1'b0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_defaults();
    t_routing();
    t_detect(3'h3, 8'h9f, 2'h1, 1'b0, 1'b1, 3'h7);
    t_detect(3'h3, 8'h9b, 2'h0, 1'b1, 1'b0, 3'h6);
    t_detect(3'h5, 8'h8f, 2'h2, 1'b0, 1'b1, 3'h0);
    bias_sw_on <= 3'h4;
    t_detect(3'h6, 8'h1f, 2'h3, 1'b1, 1'b0, 3'h1);
    summarize();
  end
endmodule : test_accessory_impedance_detect_control
